// ---- sfr_pkg.sv ----
// constants, types and register map of the serial flash read host
// assumes a host clock of 25 MHz and a flash that follows the read protocol below
package sfr_pkg;
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned SCK_MAX_READ_HZ = 50_000_000;
  localparam int unsigned SCK_MAX_MIO_HZ = 133_000_000;
  localparam int unsigned AXI_AW = 8;
  // ==========================================================
  // register map
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_COUNT = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0c;
  localparam logic [7:0] REG_RDATA = 8'h10;
  localparam int unsigned CTRL_OPC_LSB = 0;
  localparam int unsigned CTRL_ADDR4_BIT = 8;
  localparam int unsigned CTRL_QUAD_INSTR_BIT = 9;
  localparam int unsigned CTRL_QE_BIT = 10;
  localparam int unsigned CTRL_LAT_LSB = 12;
  localparam int unsigned CTRL_MODE_LSB = 16;
  localparam int unsigned CTRL_START_BIT = 31;
  localparam int unsigned ST_BUSY_BIT = 0;
  localparam int unsigned ST_RVALID_BIT = 1;
  localparam int unsigned ST_ERR_BIT = 2;
  localparam logic [15:0] COUNT_RST = 16'h0001;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ==========================================================
  // opcodes and link constants
  localparam logic [7:0] OPC_READ = 8'h03;
  localparam logic [7:0] OPC_READ_LONG = 8'h13;
  localparam logic [7:0] OPC_FAST = 8'h0b;
  localparam logic [7:0] OPC_FAST_LONG = 8'h0c;
  localparam logic [7:0] OPC_DUAL = 8'hbb;
  localparam logic [7:0] OPC_DUAL_LONG = 8'hbc;
  localparam logic [7:0] OPC_QUAD = 8'heb;
  localparam logic [7:0] OPC_QUAD_LONG = 8'hec;
  localparam logic [3:0] MODE_FORBID_HI = 4'ha;
  localparam logic [3:0] MODE_SAFE_HI = 4'h0;
  localparam logic [2:0] W1 = 3'h1;
  localparam logic [2:0] W2 = 3'h2;
  localparam logic [2:0] W4 = 3'h4;
  localparam logic [5:0] INSTR_CYC_SER = 6'h08;
  localparam logic [5:0] INSTR_CYC_QUAD = 6'h02;
  localparam logic [5:0] MODE_CYC_DUAL = 6'h04;
  localparam logic [5:0] MODE_CYC_QUAD = 6'h02;
  localparam logic [5:0] DUAL_REL_CYC = 6'h02;
  // ==========================================================
  // types
  typedef enum logic [5:0] {
    S_IDLE = 6'b000001,
    S_INSTR = 6'b000010,
    S_ADDR = 6'b000100,
    S_MODE = 6'b001000,
    S_DUMMY = 6'b010000,
    S_DATA = 6'b100000
  } sfr_state_e;
  typedef struct packed {
    logic [7:0] mode;
    logic [3:0] latency;
    logic quad_en;
    logic quad_instruction_mode;
    logic addr_long;
    logic [7:0] opcode;
  } sfr_cfg_s;
endpackage

// ---- sfr_sck_gen.sv ----
// serial clock generator: divides clk into a mode-0 sck with edge enables
// assumes run is held low to freeze sck at its present level
`timescale 1ns/10ps
module sfr_sck_gen #(
  parameter int unsigned HALF = 4
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic run,
  output logic sck,
  output logic rise,
  output logic fall
);
  localparam int unsigned CW = (HALF > 1) ? $clog2(HALF) : 1;
  localparam logic [CW-1:0] LAST = CW'(HALF - 1);
  logic [CW-1:0] cnt_reg;
  logic sck_reg;
  wire logic wrap = run && (cnt_reg == LAST);
  assign sck = sck_reg;
  assign rise = wrap && !sck_reg;
  assign fall = wrap && sck_reg;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_reg <= '0;
      sck_reg <= 1'b0;
    end else if (!run) begin
      cnt_reg <= '0;
    end else if (wrap) begin
      cnt_reg <= '0;
      sck_reg <= !sck_reg;
    end else begin
      cnt_reg <= cnt_reg + 1'b1;
    end
  end
endmodule // sfr_sck_gen

// ---- sfr_host.sv ----
// host controller for serial flash SDR reads: single, fast, dual and quad I/O
// assumes an AXI4-Lite master for orders and a flash on sck, cs_n and io pins
`timescale 1ns/10ps
module sfr_host #(
  parameter int unsigned HALF = 4
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [sfr_pkg::AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [sfr_pkg::AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic sck,
  output logic cs_n,
  output logic [3:0] io_out,
  output logic [3:0] io_oe_n,
  input wire logic [3:0] io_in
);
  // sampling needs two sync stages plus margin inside a half period
  if (HALF < 3) begin : g_bad_half
    $error("HALF must be at least 3");
  end
  if (sfr_pkg::CLK_HZ / (2 * HALF) > sfr_pkg::SCK_MAX_READ_HZ) begin : g_bad_rate
    $error("sck too fast for single read");
  end
  if (sfr_pkg::CLK_HZ / (2 * HALF) > sfr_pkg::SCK_MAX_MIO_HZ) begin : g_bad_mio
    $error("sck too fast for fast, dual or quad read");
  end

  // ==========================================================
  // register bus
  logic awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
  logic [1:0] bresp_reg, rresp_reg;
  logic [31:0] rdata_reg, wdata_hold_reg;
  logic [3:0] wstrb_hold_reg;
  logic [7:0] awaddr_hold_reg;
  logic aw_held_reg, w_held_reg;
  sfr_pkg::sfr_cfg_s cfg_reg;
  logic [31:0] addr_reg;
  logic [15:0] count_reg;
  logic err_reg, start_pend_reg, rxf_reg;
  logic [7:0] rx_byte_reg;
  sfr_pkg::sfr_state_e state_reg, nstate;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return r;
  endfunction

  wire logic aw_hs = s_axi_awvalid && awready_reg;
  wire logic w_hs = s_axi_wvalid && wready_reg;
  wire logic ar_hs = s_axi_arvalid && arready_reg;
  wire logic do_wr = aw_held_reg && w_held_reg && !bvalid_reg;
  wire logic busy = (state_reg != sfr_pkg::S_IDLE) || start_pend_reg;
  wire logic [31:0] ctrl_word = {8'h00, cfg_reg.mode, cfg_reg.latency, 1'b0, cfg_reg.quad_en,
                                 cfg_reg.quad_instruction_mode, cfg_reg.addr_long,
                                 cfg_reg.opcode};
  wire logic [31:0] ctrl_new = merge(ctrl_word, wdata_hold_reg, wstrb_hold_reg);
  wire logic [31:0] addr_new = merge(addr_reg, wdata_hold_reg, wstrb_hold_reg);
  wire logic [31:0] count_new = merge({16'h0000, count_reg}, wdata_hold_reg, wstrb_hold_reg);
  wire logic wr_ctrl = do_wr && awaddr_hold_reg == sfr_pkg::REG_CTRL;
  wire logic wr_addr = do_wr && awaddr_hold_reg == sfr_pkg::REG_ADDR && !busy;
  wire logic wr_count = do_wr && awaddr_hold_reg == sfr_pkg::REG_COUNT && !busy;
  wire logic wr_status = do_wr && awaddr_hold_reg == sfr_pkg::REG_STATUS;
  wire logic wr_known = awaddr_hold_reg == sfr_pkg::REG_CTRL ||
                        awaddr_hold_reg == sfr_pkg::REG_ADDR ||
                        awaddr_hold_reg == sfr_pkg::REG_COUNT ||
                        awaddr_hold_reg == sfr_pkg::REG_STATUS;
  // settings are frozen while a read runs so the sequence stays consistent
  wire logic cfg_load = wr_ctrl && !busy;
  wire logic start_req = cfg_load && ctrl_new[sfr_pkg::CTRL_START_BIT];
  wire logic err_clr = wr_status && wdata_hold_reg[sfr_pkg::ST_ERR_BIT] &&
                       wstrb_hold_reg[0];
  wire logic rd_rdata = ar_hs && s_axi_araddr == sfr_pkg::REG_RDATA;
  wire logic [31:0] status_word = {29'h0, err_reg, rxf_reg, busy};
  wire logic rd_known = s_axi_araddr == sfr_pkg::REG_CTRL ||
                        s_axi_araddr == sfr_pkg::REG_ADDR ||
                        s_axi_araddr == sfr_pkg::REG_COUNT ||
                        s_axi_araddr == sfr_pkg::REG_STATUS ||
                        s_axi_araddr == sfr_pkg::REG_RDATA;
  wire logic [31:0] rd_word =
    (s_axi_araddr == sfr_pkg::REG_CTRL) ? ctrl_word :
    (s_axi_araddr == sfr_pkg::REG_ADDR) ? addr_reg :
    (s_axi_araddr == sfr_pkg::REG_COUNT) ? {16'h0000, count_reg} :
    (s_axi_araddr == sfr_pkg::REG_STATUS) ? status_word :
    (s_axi_araddr == sfr_pkg::REG_RDATA) ? {24'h000000, rx_byte_reg} : 32'h00000000;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      awready_reg <= 1'b1;
      wready_reg <= 1'b1;
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      awaddr_hold_reg <= 8'h00;
      wdata_hold_reg <= 32'h00000000;
      wstrb_hold_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= sfr_pkg::RESP_OKAY;
    end else begin
      if (aw_hs) begin
        awaddr_hold_reg <= s_axi_awaddr;
        aw_held_reg <= 1'b1;
        awready_reg <= 1'b0;
      end
      if (w_hs) begin
        wdata_hold_reg <= s_axi_wdata;
        wstrb_hold_reg <= s_axi_wstrb;
        w_held_reg <= 1'b1;
        wready_reg <= 1'b0;
      end
      if (do_wr) begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg <= wr_known ? sfr_pkg::RESP_OKAY : sfr_pkg::RESP_SLVERR;
      end
      if (bvalid_reg && s_axi_bready) begin
        bvalid_reg <= 1'b0;
        awready_reg <= 1'b1;
        wready_reg <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      arready_reg <= 1'b1;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
      rresp_reg <= sfr_pkg::RESP_OKAY;
    end else if (ar_hs) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b1;
      rdata_reg <= rd_word;
      rresp_reg <= rd_known ? sfr_pkg::RESP_OKAY : sfr_pkg::RESP_SLVERR;
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_reg <= 1'b0;
      arready_reg <= 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cfg_reg <= '0;
      addr_reg <= 32'h00000000;
      count_reg <= sfr_pkg::COUNT_RST;
    end else begin
      if (cfg_load) begin
        cfg_reg.opcode <= ctrl_new[sfr_pkg::CTRL_OPC_LSB +: 8];
        cfg_reg.addr_long <= ctrl_new[sfr_pkg::CTRL_ADDR4_BIT];
        cfg_reg.quad_instruction_mode <= ctrl_new[sfr_pkg::CTRL_QUAD_INSTR_BIT];
        cfg_reg.quad_en <= ctrl_new[sfr_pkg::CTRL_QE_BIT];
        cfg_reg.latency <= ctrl_new[sfr_pkg::CTRL_LAT_LSB +: 4];
        cfg_reg.mode <= ctrl_new[sfr_pkg::CTRL_MODE_LSB +: 8];
      end
      if (wr_addr) begin
        addr_reg <= addr_new;
      end
      if (wr_count) begin
        count_reg <= count_new[15:0];
      end
    end
  end

  // ==========================================================
  // command decode
  wire logic [7:0] opc = cfg_reg.opcode;
  wire logic is_read = opc == sfr_pkg::OPC_READ || opc == sfr_pkg::OPC_READ_LONG;
  wire logic is_fast = opc == sfr_pkg::OPC_FAST || opc == sfr_pkg::OPC_FAST_LONG;
  wire logic is_dual = opc == sfr_pkg::OPC_DUAL || opc == sfr_pkg::OPC_DUAL_LONG;
  wire logic is_quad = opc == sfr_pkg::OPC_QUAD || opc == sfr_pkg::OPC_QUAD_LONG;
  wire logic long_opc = opc == sfr_pkg::OPC_READ_LONG || opc == sfr_pkg::OPC_FAST_LONG ||
                        opc == sfr_pkg::OPC_DUAL_LONG || opc == sfr_pkg::OPC_QUAD_LONG;
  wire logic addr4 = long_opc || cfg_reg.addr_long;
  wire logic quad_instr = is_quad && cfg_reg.quad_instruction_mode;
  wire logic bad_cmd = !(is_read || is_fast || is_dual || is_quad) ||
                       (is_quad && !cfg_reg.quad_en) || count_reg == 16'h0000;
  wire logic [2:0] dw = is_quad ? sfr_pkg::W4 : is_dual ? sfr_pkg::W2 : sfr_pkg::W1;
  wire logic [2:0] iw = quad_instr ? sfr_pkg::W4 : sfr_pkg::W1;
  wire logic [5:0] instr_cyc = quad_instr ? sfr_pkg::INSTR_CYC_QUAD : sfr_pkg::INSTR_CYC_SER;
  wire logic [5:0] addr_bits = addr4 ? 6'h20 : 6'h18;
  wire logic [5:0] addr_cyc = is_quad ? {2'b00, addr_bits[5:2]} :
                              is_dual ? {1'b0, addr_bits[5:1]} : addr_bits;
  wire logic [5:0] mode_cyc = is_dual ? sfr_pkg::MODE_CYC_DUAL :
                              is_quad ? sfr_pkg::MODE_CYC_QUAD : 6'h00;
  wire logic [5:0] dummy_cyc = is_read ? 6'h00 : {2'b00, cfg_reg.latency};
  wire logic [5:0] byte_cyc = is_quad ? 6'h02 : is_dual ? 6'h04 : 6'h08;
  // never let the mode byte ask for continuous read
  wire logic [7:0] mode_safe = (cfg_reg.mode[7:4] == sfr_pkg::MODE_FORBID_HI) ?
                               {sfr_pkg::MODE_SAFE_HI, cfg_reg.mode[3:0]} : cfg_reg.mode;
  // a short address must be followed directly by the mode byte, padding goes last
  wire logic [47:0] tx_init = addr4 ? {opc, addr_reg, mode_safe} :
                              {opc, addr_reg[23:0], mode_safe, 8'h00};

  // ==========================================================
  // link sequencer
  logic sck_i, rise, fall, run;
  logic [5:0] cnt_reg, ncnt;
  logic [15:0] left_reg;
  logic [47:0] tx_reg;
  logic [7:0] rx_reg;
  logic [3:0] io_out_reg, io_oe_n_reg, io_meta_reg, io_sync_reg;
  logic cs_n_reg, end_now;

  function automatic logic [3:0] pick(input logic [47:0] v, input logic [2:0] w);
    unique case (w)
      sfr_pkg::W1: return {3'b000, v[47]};
      sfr_pkg::W2: return {2'b00, v[47:46]};
      default: return v[47:44];
    endcase
  endfunction

  function automatic logic [3:0] oe_of(input sfr_pkg::sfr_state_e s, input logic [2:0] w,
                                       input logic rel);
    if ((s == sfr_pkg::S_INSTR || s == sfr_pkg::S_ADDR || s == sfr_pkg::S_MODE) && !rel) begin
      unique case (w)
        sfr_pkg::W1: return 4'b1110;
        sfr_pkg::W2: return 4'b1100;
        default: return 4'b0000;
      endcase
    end
    return 4'b1111;
  endfunction

  always_comb begin
    nstate = state_reg;
    ncnt = cnt_reg - 6'h01;
    end_now = 1'b0;
    if (cnt_reg == 6'h00) begin
      unique case (state_reg)
        sfr_pkg::S_INSTR: begin
          nstate = sfr_pkg::S_ADDR;
          ncnt = addr_cyc - 6'h01;
        end
        sfr_pkg::S_ADDR: begin
          nstate = (mode_cyc != 6'h00) ? sfr_pkg::S_MODE :
                   (dummy_cyc != 6'h00) ? sfr_pkg::S_DUMMY : sfr_pkg::S_DATA;
          ncnt = (mode_cyc != 6'h00) ? mode_cyc - 6'h01 :
                 (dummy_cyc != 6'h00) ? dummy_cyc - 6'h01 : byte_cyc - 6'h01;
        end
        sfr_pkg::S_MODE: begin
          nstate = (dummy_cyc != 6'h00) ? sfr_pkg::S_DUMMY : sfr_pkg::S_DATA;
          ncnt = (dummy_cyc != 6'h00) ? dummy_cyc - 6'h01 : byte_cyc - 6'h01;
        end
        sfr_pkg::S_DUMMY: begin
          nstate = sfr_pkg::S_DATA;
          ncnt = byte_cyc - 6'h01;
        end
        sfr_pkg::S_DATA: begin
          end_now = left_reg == 16'h0000;
          ncnt = byte_cyc - 6'h01;
        end
        sfr_pkg::S_IDLE: begin
          ncnt = 6'h00;
        end
      endcase
    end
  end

  wire logic [2:0] cur_w = (state_reg == sfr_pkg::S_INSTR) ? iw : dw;
  wire logic [2:0] nw = (nstate == sfr_pkg::S_INSTR) ? iw : dw;
  wire logic [47:0] tx_shift = tx_reg << cur_w;
  // the low mode nibble of a dual read is not needed, so drive is dropped early
  wire logic nrel = is_dual && nstate == sfr_pkg::S_MODE && ncnt < sfr_pkg::DUAL_REL_CYC;
  wire logic [7:0] rx_next = is_quad ? {rx_reg[3:0], io_sync_reg} :
                             is_dual ? {rx_reg[5:0], io_sync_reg[1:0]} :
                             {rx_reg[6:0], io_sync_reg[1]};
  wire logic byte_done = rise && state_reg == sfr_pkg::S_DATA && cnt_reg == 6'h00;
  // sck is held high at a byte boundary until software takes the last byte
  wire logic stall = state_reg == sfr_pkg::S_DATA && cnt_reg == 6'h00 &&
                     left_reg != 16'h0000 && rxf_reg && sck_i;
  assign run = state_reg != sfr_pkg::S_IDLE && !stall;

  sfr_sck_gen #(.HALF(HALF)) u_sck (
    .clk(clk),
    .rst(rst),
    .run(run),
    .sck(sck_i),
    .rise(rise),
    .fall(fall)
  );

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      io_meta_reg <= 4'h0;
      io_sync_reg <= 4'h0;
    end else begin
      io_meta_reg <= io_in;
      io_sync_reg <= io_meta_reg;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= sfr_pkg::S_IDLE;
      start_pend_reg <= 1'b0;
      cnt_reg <= 6'h00;
      left_reg <= 16'h0000;
      tx_reg <= '0;
      rx_reg <= 8'h00;
      io_out_reg <= 4'h0;
      io_oe_n_reg <= 4'hf;
      cs_n_reg <= 1'b1;
    end else begin
      start_pend_reg <= start_req;
      if (start_pend_reg && !bad_cmd) begin
        state_reg <= sfr_pkg::S_INSTR;
        cnt_reg <= instr_cyc - 6'h01;
        left_reg <= count_reg;
        tx_reg <= tx_init;
        io_out_reg <= pick(tx_init, iw);
        io_oe_n_reg <= oe_of(sfr_pkg::S_INSTR, iw, 1'b0);
        cs_n_reg <= 1'b0;
      end else if (fall && end_now) begin
        state_reg <= sfr_pkg::S_IDLE;
        io_oe_n_reg <= 4'hf;
        cs_n_reg <= 1'b1;
      end else if (fall) begin
        state_reg <= nstate;
        cnt_reg <= ncnt;
        tx_reg <= tx_shift;
        io_out_reg <= pick(tx_shift, nw);
        io_oe_n_reg <= oe_of(nstate, nw, nrel);
      end else if (rise && state_reg == sfr_pkg::S_DATA) begin
        rx_reg <= rx_next;
        if (cnt_reg == 6'h00) begin
          left_reg <= left_reg - 16'h0001;
        end
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      err_reg <= 1'b0;
      rxf_reg <= 1'b0;
      rx_byte_reg <= 8'h00;
    end else begin
      err_reg <= (start_pend_reg && bad_cmd) || (err_reg && !err_clr);
      rxf_reg <= byte_done || (rxf_reg && !rd_rdata);
      if (byte_done) begin
        rx_byte_reg <= rx_next;
      end
    end
  end

  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign sck = sck_i;
  assign cs_n = cs_n_reg;
  assign io_out = io_out_reg;
  assign io_oe_n = io_oe_n_reg;
endmodule // sfr_host

// ---- sfr_host_chk.sv ----
// checker of the flash pins of the read host
// assumes binding into sfr_host; sees its ports only
`timescale 1ns/10ps
module sfr_host_chk (
  input wire logic clk,
  input wire logic rst,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic [3:0] io_out,
  input wire logic [3:0] io_oe_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // ==========================================================
  // link properties
  property p_idle; cs_n |-> io_oe_n == 4'hf && !sck; endproperty
  a_idle: assert property (p_idle) else $error("pins driven outside a frame");
  property p_hi; $rose(sck) |=> sck ##1 sck; endproperty
  a_hi: assert property (p_hi) else $error("sck high too short");
  property p_lo; $fell(sck) |=> !sck ##1 !sck; endproperty
  a_lo: assert property (p_lo) else $error("sck low too short");
  property p_setup; $rose(sck) |-> $stable(io_out) && $stable(io_oe_n); endproperty
  a_setup: assert property (p_setup) else $error("io moved at sck rise");
  property p_start; $fell(cs_n) |-> !io_oe_n[0]; endproperty
  a_start: assert property (p_start) else $error("frame opened undriven");
  property p_end; $rose(cs_n) |-> $past(io_oe_n) == 4'hf; endproperty
  a_end: assert property (p_end) else $error("frame closed before data");
  property p_keep; !cs_n && $past(!cs_n) && $past(io_oe_n[0]) |-> io_oe_n[0]; endproperty
  a_keep: assert property (p_keep) else $error("io0 driven again after release");
  property p_quad; !io_oe_n[3] |-> !io_oe_n[0] && !io_oe_n[2]; endproperty
  a_quad: assert property (p_quad) else $error("partial quad drive");
  c_frame: cover property ($rose(cs_n));
  c_quad: cover property (!io_oe_n[3]);
  c_turn: cover property ($rose(io_oe_n[1]) && !cs_n);
endmodule // sfr_host_chk
bind sfr_host sfr_host_chk i_chk (.clk(clk), .rst(rst), .sck(sck), .cs_n(cs_n),
  .io_out(io_out), .io_oe_n(io_oe_n));

// ---- sfr_flash_model.sv ----
// behavioural serial flash answering sdr read commands
// assumes its config inputs match what the host was told
`timescale 1ns/10ps
module sfr_flash_model #(
  parameter logic [31:0] MASK = 32'h00ff_ffff
) (
  input wire logic sck,
  input wire logic cs_n,
  input wire logic [3:0] io,
  input wire logic a4,
  input wire logic quad_instr,
  input wire logic qe,
  input wire logic [3:0] lat,
  output logic [3:0] q,
  output logic [7:0] op,
  output logic [31:0] adr,
  output logic [7:0] mode
);
  // ==========================================================
  // frame
  task automatic sh(input int n, input int w, output logic [31:0] v);
    v = 0;
    repeat (n) begin
      @(posedge sck);
      v = (v << w) | 32'(io & 4'((1 << w) - 1));
    end
  endtask
  task automatic frame();
    logic [31:0] v, a;
    logic [7:0] d;
    int w;
    sh(quad_instr ? 2 : 8, quad_instr ? 4 : 1, v);
    op = v[7:0];
    w = op inside {8'heb, 8'hec} ? 4 : op inside {8'hbb, 8'hbc} ? 2 : 1;
    if (w == 4 && !qe) @(posedge cs_n);
    sh(((a4 || op inside {8'h13, 8'h0c, 8'hbc, 8'hec}) ? 32 : 24) / w, w, a);
    adr = a;
    sh(w == 4 ? 2 : w == 2 ? 4 : 0, w, v);
    mode = v[7:0];
    if (op != 8'h03 && op != 8'h13) repeat (lat) @(negedge sck);
    forever begin
      d = a[7:0] ^ a[23:16] ^ 8'h3c;
      for (int k = 8 - w; k >= 0; k -= w) begin
        @(negedge sck);
        q = w == 1 ? {2'h0, d[k], 1'h0} : 4'(d >> k);
      end
      a = (a + 1) & MASK;
    end
  endtask
  initial begin
    q = 4'h5;
    forever begin
      @(negedge cs_n);
      fork
        frame();
        @(posedge cs_n);
      join_any
      disable fork;
      q = ~q;
    end
  end
endmodule // sfr_flash_model

// ---- sfr_host_test.sv ----
// self-checking bench: axi orders in, flash model on the pins
// assumes the flash model and the checker are compiled first
`timescale 1ns/10ps
module sfr_host_test;
  localparam logic [31:0] MASK = 32'h00ff_ffff;
  logic clk = 0, rst = 1, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, m_a4 = 0, m_qinstr = 0, m_qe = 0;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0, op, mode;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, adr;
  logic [3:0] s_axi_wstrb = 4'hf, m_lat = 0, io_out, io_oe_n, fq;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, sck, cs_n;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  wire logic [3:0] io_in = (~io_oe_n & io_out) | (io_oe_n & fq);
  int mismatches = 0, checks = 0, cyc = 0, nfr = 0;
  sfr_host #(.HALF(3)) i_dut (.clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .sck, .cs_n, .io_out, .io_oe_n, .io_in);
  sfr_flash_model #(.MASK(MASK)) i_flash (.sck(sck), .cs_n(cs_n), .io(io_in), .a4(m_a4),
    .quad_instr(m_qinstr), .qe(m_qe), .lat(m_lat), .q(fq), .op(op), .adr(adr), .mode(mode));
  always #20 clk = ~clk;
  always @(negedge cs_n) nfr++;
  // ==========================================================
  // bus tasks
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    bit pa, pw, ta, tw;
    @(posedge clk);
    {s_axi_awaddr, s_axi_wdata} <= {a, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    {pa, pw} = 2'h3;
    while (pa || pw) begin
      @(negedge clk);
      {ta, tw} = {pa && s_axi_awready, pw && s_axi_wready};
      @(posedge clk);
      if (ta) s_axi_awvalid <= 0;
      if (tw) s_axi_wvalid <= 0;
      {pa, pw} = {pa && !ta, pw && !tw};
    end
    do @(negedge clk); while (s_axi_bvalid !== 1);
    chk(s_axi_bresp, e);
    @(posedge clk);
    s_axi_bready <= 0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
    do @(negedge clk); while (s_axi_arready !== 1);
    @(posedge clk);
    s_axi_arvalid <= 0;
    do @(negedge clk); while (s_axi_rvalid !== 1);
    {d, r} = {s_axi_rdata, s_axi_rresp};
    @(posedge clk);
    s_axi_rready <= 0;
  endtask
  // one read: data compared byte by byte, then what reached the pins
  task automatic rdf(input logic [7:0] o, input logic [3:0] l, input logic [31:0] a, int n);
    logic [31:0] d, x;
    logic [1:0] r;
    m_lat = l;
    wr(sfr_pkg::REG_ADDR, a, sfr_pkg::RESP_OKAY);
    wr(sfr_pkg::REG_COUNT, 32'(n), sfr_pkg::RESP_OKAY);
    wr(sfr_pkg::REG_CTRL, {8'h80, 8'ha5, l, 1'b0, m_qe, m_qinstr, m_a4, o}, sfr_pkg::RESP_OKAY);
    for (int i = 0; i < n; i++) begin
      do rd(sfr_pkg::REG_STATUS, d, r); while (d[1] !== 1);
      rd(sfr_pkg::REG_RDATA, d, r);
      x = (a + i) & MASK;
      chk(d, {24'h0, x[7:0] ^ x[23:16] ^ 8'h3c});
    end
    do rd(sfr_pkg::REG_STATUS, d, r); while (d[0] !== 0);
    x = (m_a4 || o inside {8'h13, 8'h0c, 8'hbc, 8'hec}) ? a : a & MASK;
    chk(adr, x);
    chk({op, mode[7:4]}, {o, 4'h0});
    if (o inside {sfr_pkg::OPC_QUAD, sfr_pkg::OPC_QUAD_LONG}) begin
      chk(mode, {sfr_pkg::MODE_SAFE_HI, 4'h5});
    end
  endtask
  // ==========================================================
  // scenarios
  task automatic t_regs();
    logic [31:0] d;
    logic [1:0] r;
    rd(sfr_pkg::REG_COUNT, d, r);
    chk(d, 32'h1);
    rd(8'h20, d, r);
    chk({d[29:0], r}, {30'h0, sfr_pkg::RESP_SLVERR});
    wr(8'h20, 32'h1, sfr_pkg::RESP_SLVERR);
    $display("regs done");
  endtask
  task automatic t_single();
    rdf(sfr_pkg::OPC_READ, 4'h9, 32'h0012_3456, 2);
    m_a4 = 1;
    rdf(sfr_pkg::OPC_READ, 4'h0, 32'h5a00_00ff, 1);
    m_a4 = 0;
    rdf(sfr_pkg::OPC_READ_LONG, 4'h0, 32'h0100_0010, 1);
    $display("single done");
  endtask
  task automatic t_fast();
    rdf(sfr_pkg::OPC_FAST, 4'h2, 32'h00ff_fffe, 3);
    rdf(sfr_pkg::OPC_FAST_LONG, 4'hf, 32'h0200_0080, 1);
    $display("fast done");
  endtask
  task automatic t_dual();
    rdf(sfr_pkg::OPC_DUAL, 4'h1, 32'h0000_a5c3, 2);
    rdf(sfr_pkg::OPC_DUAL_LONG, 4'h0, 32'h3300_0001, 1);
    $display("dual done");
  endtask
  task automatic t_quad();
    m_qe = 1;
    rdf(sfr_pkg::OPC_QUAD, 4'h0, 32'h0080_7f00, 2);
    rdf(sfr_pkg::OPC_QUAD_LONG, 4'h3, 32'h0401_0203, 1);
    m_qinstr = 1;
    rdf(sfr_pkg::OPC_QUAD, 4'h2, 32'h0000_0100, 1);
    {m_qinstr, m_qe} = 2'h0;
    $display("quad done");
  endtask
  task automatic t_refuse();
    logic [31:0] d;
    logic [1:0] r;
    int k;
    k = nfr;
    wr(sfr_pkg::REG_CTRL, {8'h80, 16'h0, sfr_pkg::OPC_QUAD}, sfr_pkg::RESP_OKAY);
    do rd(sfr_pkg::REG_STATUS, d, r); while (d[0] !== 0);
    chk(d, 32'h4);
    chk(32'(nfr - k), 32'h0);
    wr(sfr_pkg::REG_STATUS, 32'h4, sfr_pkg::RESP_OKAY);
    rd(sfr_pkg::REG_STATUS, d, r);
    chk(d, 32'h0);
    // a zero byte count is refused the same way, with no frame opened
    wr(sfr_pkg::REG_COUNT, 32'h0, sfr_pkg::RESP_OKAY);
    wr(sfr_pkg::REG_CTRL, {8'h80, 16'h0, sfr_pkg::OPC_READ}, sfr_pkg::RESP_OKAY);
    do rd(sfr_pkg::REG_STATUS, d, r); while (d[0] !== 0);
    chk(d, 32'h4);
    chk(32'(nfr - k), 32'h0);
    $display("refuse done");
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // a hang is cut short well above the few thousand cycles the run needs
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      mismatches++;
      final_report();
    end
  end
  initial begin
    repeat (5) @(posedge clk);
    rst <= 0;
    t_regs();
    t_single();
    t_fast();
    t_dual();
    t_quad();
    t_refuse();
    final_report();
  end
endmodule // sfr_host_test
